//--- icb_pkg.sv
// constants, register map and state types for the serial control port
// assumes a 25 MHz ref_clk and a master running standard-mode timing
package icb_pkg;

  // ----------------------------------------------------------------------
  // register bank layout
  // ----------------------------------------------------------------------
  localparam int unsigned BANK_SIZE  = 128;       // locations reachable
  localparam int unsigned RW_COUNT   = 81;        // stored locations 0..80
  localparam logic [6:0]  RW_LAST    = 7'h50;     // last writable location
  localparam logic [6:0]  RO_FIRST   = 7'h60;     // first read-only location
  localparam logic [6:0]  SOFT_CLIP_OFS   = 7'h0A; // soft_clip_control
  localparam logic [6:0]  FAULT_CTRL_OFS  = 7'h2D; // fault_handling_control
  localparam logic [6:0]  MOD_IDX0_OFS    = 7'h62; // modulation_index_ch0
  localparam logic [6:0]  MOD_IDX1_OFS    = 7'h66; // modulation_index_ch1
  localparam logic [6:0]  FAULT_ACC_OFS   = 7'h6D; // fault_accumulated
  localparam logic [6:0]  FAULT_LIVE_OFS  = 7'h7C; // fault_live_status
  localparam int unsigned SOFT_CLIP_BIT   = 7;
  localparam int unsigned FAULT_CLR_BIT   = 2;     // fault_log_clear
  localparam logic [7:0]  BANK_RST   = 8'h00;     // value after reset

  // ----------------------------------------------------------------------
  // fault vector bit positions
  // ----------------------------------------------------------------------
  localparam int unsigned FLT_DC_GUARD  = 7;
  localparam int unsigned FLT_PIN_SHORT = 6;
  localparam int unsigned FLT_OT_ERR    = 5;
  localparam int unsigned FLT_OT_WARN   = 4;
  localparam int unsigned FLT_UNDERVOLT = 3;
  localparam int unsigned FLT_CLK_LOCK  = 2;
  localparam int unsigned FLT_OVERCURR  = 1;
  localparam int unsigned FLT_CAP_OV    = 0;

  // ----------------------------------------------------------------------
  // bus address and protocol counts
  // ----------------------------------------------------------------------
  localparam logic [4:0]  SLAVE_ADDR_HI = 5'h08;  // fixed upper five bits
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam int unsigned SYNC_W        = 15;     // pins passed through sync

  // output configuration strap codes {out_cfg_sel0, out_cfg_sel1}
  localparam logic [1:0]  CFG_PAR_BRIDGE  = 2'h0; // one parallel bridge
  localparam logic [1:0]  CFG_MIXED       = 2'h1; // two single, one bridge
  localparam logic [1:0]  CFG_TWO_BRIDGE  = 2'h2; // two bridge channels
  localparam logic [1:0]  CFG_FOUR_SINGLE = 2'h3; // four single-ended

  // ----------------------------------------------------------------------
  // serial engine states
  // ----------------------------------------------------------------------
  typedef enum logic [8:0] {
    ST_IDLE      = 9'h001,
    ST_ADDR      = 9'h002,
    ST_ADDR_ACK  = 9'h004,
    ST_REG       = 9'h008,
    ST_REG_ACK   = 9'h010,
    ST_WDATA     = 9'h020,
    ST_WDATA_ACK = 9'h040,
    ST_RDATA     = 9'h080,
    ST_RDATA_ACK = 9'h100
  } icb_state_e;

  typedef struct packed {
    icb_state_e               state;
    logic [3:0]               cnt;
    logic [7:0]               shreg;
    logic [6:0]               ptr;
    logic                     rw;
    logic                     more;
    logic                     sda_oe;
    logic                     scl_d;
    logic                     sda_d;
    logic [7:0]               live;
    logic [7:0]               acc;
    logic                     clr_prev;
    logic                     near_oe;
    logic                     fault_oe;
    logic                     par_bridge;
    logic                     bridge;
    logic                     single_end;
    logic [RW_COUNT-1:0][7:0] mem;
  } icb_state_s;

endpackage : icb_pkg

//--- icb_sync.sv
// two-stage synchroniser for pins that come from outside ref_clk
// assumes nothing of its inputs but that they are single-bit levels
`timescale 1ns/1ps
`default_nettype none
module icb_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } icb_sync_s;

  icb_sync_s st_ff;
  icb_sync_s nxt_st;

  // first stage feeds only the second stage
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = d;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.s2;

endmodule : icb_sync
`default_nettype wire

//--- icb_ctrl_port.sv
// serial control port with 128-location register bank, fault and clip pins
// assumes scl/sda and all straps and flags are asynchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module icb_ctrl_port
  import icb_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output var  logic       sda_out,
  output var  logic       sda_oe,
  input  wire logic       addr_select_0,
  input  wire logic       addr_select_1,
  input  wire logic       out_cfg_sel0,
  input  wire logic       out_cfg_sel1,
  input  wire logic       direct_current_guard_flag,
  input  wire logic       pin_short_flag,
  input  wire logic       overtemp_error_flag,
  input  wire logic       overtemp_warning_flag,
  input  wire logic       undervoltage_flag,
  input  wire logic       clock_lock_fault,
  input  wire logic       overcurrent_flag,
  input  wire logic       cap_overvoltage_flag,
  input  wire logic       near_clip,
  input  wire logic [7:0] mod_index_ch0,
  input  wire logic [7:0] mod_index_ch1,
  output var  logic       near_saturation_n_out,
  output var  logic       near_saturation_n_oe,
  output var  logic       fault_n_out,
  output var  logic       fault_n_oe,
  output var  logic       soft_clip_en,
  output var  logic       parallel_bridge_mode,
  output var  logic       bridge_mode,
  output var  logic       single_ended_mode
);

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] syn;
  logic              scl;
  logic              sda;
  logic [1:0]        adr_lo;
  logic [1:0]        cfg;
  logic [7:0]        flt;
  logic              clip_s;

  // fault flags packed in their register order
  always_comb begin
    raw_in = '0;
    raw_in[FLT_DC_GUARD]  = direct_current_guard_flag;
    raw_in[FLT_PIN_SHORT] = pin_short_flag;
    raw_in[FLT_OT_ERR]    = overtemp_error_flag;
    raw_in[FLT_OT_WARN]   = overtemp_warning_flag;
    raw_in[FLT_UNDERVOLT] = undervoltage_flag;
    raw_in[FLT_CLK_LOCK]  = clock_lock_fault;
    raw_in[FLT_OVERCURR]  = overcurrent_flag;
    raw_in[FLT_CAP_OV]    = cap_overvoltage_flag;
    raw_in[14:8] = {scl_in, sda_in, addr_select_1, addr_select_0,
                    out_cfg_sel0, out_cfg_sel1, near_clip};
  end

  icb_sync #(.W(SYNC_W)) u_sync (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .d       (raw_in),
    .q       (syn)
  );

  assign flt    = syn[7:0];
  assign clip_s = syn[8];
  assign cfg    = syn[10:9];
  assign adr_lo = syn[12:11];
  assign sda    = syn[13];
  assign scl    = syn[14];

  // ----------------------------------------------------------------------
  // state and edge decode
  // ----------------------------------------------------------------------
  icb_state_s st_ff;
  icb_state_s nxt_st;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic       addr_hit;
  logic       clr_evt;

  // bus conditions seen on the sampled pins
  assign scl_rise  = scl & ~st_ff.scl_d;
  assign scl_fall  = ~scl & st_ff.scl_d;
  assign start_det = st_ff.scl_d & scl & st_ff.sda_d & ~sda;
  assign stop_det  = st_ff.scl_d & scl & ~st_ff.sda_d & sda;
  assign addr_hit  = st_ff.shreg[7:1] == {SLAVE_ADDR_HI, adr_lo};
  assign clr_evt   = st_ff.mem[FAULT_CTRL_OFS][FAULT_CLR_BIT]
                     != st_ff.clr_prev;

  // read view of the whole 128-location bank
  function automatic logic [7:0] rd_byte(input icb_state_s s,
                                         input logic [6:0] a);
    rd_byte = 8'h00;
    if (a <= RW_LAST) begin
      rd_byte = s.mem[a];
    end else begin
      unique case (a)
        MOD_IDX0_OFS:   rd_byte = mod_index_ch0;
        MOD_IDX1_OFS:   rd_byte = mod_index_ch1;
        FAULT_ACC_OFS:  rd_byte = s.acc;
        FAULT_LIVE_OFS: rd_byte = s.live;
        default:        rd_byte = 8'h00;
      endcase
    end
  endfunction : rd_byte

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    logic [7:0] rb;
    rb = rd_byte(st_ff, st_ff.ptr);
    nxt_st          = st_ff;
    nxt_st.scl_d    = scl;
    nxt_st.sda_d    = sda;
    // status pins and fault log, a new fault beats a clear
    nxt_st.live     = flt;
    nxt_st.acc      = (clr_evt ? 8'h00 : st_ff.acc) | st_ff.live;
    nxt_st.clr_prev = st_ff.mem[FAULT_CTRL_OFS][FAULT_CLR_BIT];
    nxt_st.near_oe  = clip_s;
    nxt_st.fault_oe = |st_ff.live;
    nxt_st.par_bridge = cfg == CFG_PAR_BRIDGE;
    nxt_st.bridge     = (cfg == CFG_MIXED) || (cfg == CFG_TWO_BRIDGE);
    nxt_st.single_end = (cfg == CFG_MIXED) || (cfg == CFG_FOUR_SINGLE);

    if (stop_det) begin
      nxt_st.state  = ST_IDLE;
      nxt_st.sda_oe = 1'b0;
    end else if (start_det) begin
      nxt_st.state  = ST_ADDR;
      nxt_st.cnt    = 4'h0;
      nxt_st.sda_oe = 1'b0;
    end else begin
      unique case (st_ff.state)
        ST_IDLE: begin
          nxt_st.sda_oe = 1'b0;
        end
        // receiving phases share the bit shifter
        ST_ADDR, ST_REG, ST_WDATA: begin
          if (scl_rise && st_ff.cnt < BITS_PER_BYTE) begin
            nxt_st.shreg = {st_ff.shreg[6:0], sda};
            nxt_st.cnt   = st_ff.cnt + 4'h1;
          end else if (scl_fall && st_ff.cnt == BITS_PER_BYTE) begin
            nxt_st.cnt = 4'h0;
            if (st_ff.state == ST_ADDR) begin
              if (addr_hit) begin
                nxt_st.rw     = st_ff.shreg[0];
                nxt_st.sda_oe = 1'b1;
                nxt_st.state  = ST_ADDR_ACK;
              end else begin
                nxt_st.state  = ST_IDLE;
              end
            end else if (st_ff.state == ST_REG) begin
              nxt_st.ptr    = st_ff.shreg[6:0];
              nxt_st.sda_oe = 1'b1;
              nxt_st.state  = ST_REG_ACK;
            end else begin
              if (st_ff.ptr <= RW_LAST) begin
                nxt_st.mem[st_ff.ptr] = st_ff.shreg;
              end
              nxt_st.ptr    = st_ff.ptr + 7'h01;
              nxt_st.sda_oe = 1'b1;
              nxt_st.state  = ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (st_ff.rw) begin
              nxt_st.shreg  = rb;
              nxt_st.sda_oe = ~rb[7];
              nxt_st.state  = ST_RDATA;
            end else begin
              nxt_st.sda_oe = 1'b0;
              nxt_st.state  = ST_REG;
            end
          end
        end
        ST_REG_ACK, ST_WDATA_ACK: begin
          if (scl_fall) begin
            nxt_st.sda_oe = 1'b0;
            nxt_st.state  = ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            nxt_st.cnt = st_ff.cnt + 4'h1;
          end else if (scl_fall) begin
            if (st_ff.cnt == BITS_PER_BYTE) begin
              nxt_st.sda_oe = 1'b0;
              nxt_st.state  = ST_RDATA_ACK;
            end else begin
              nxt_st.shreg  = {st_ff.shreg[6:0], 1'b0};
              nxt_st.sda_oe = ~st_ff.shreg[6];
            end
          end
        end
        ST_RDATA_ACK: begin
          if (scl_rise) begin
            if (!sda) begin
              nxt_st.more = 1'b1;
              nxt_st.ptr  = st_ff.ptr + 7'h01;
            end else begin
              nxt_st.state = ST_IDLE;
            end
          end else if (scl_fall && st_ff.more) begin
            nxt_st.more   = 1'b0;
            nxt_st.cnt    = 4'h0;
            nxt_st.shreg  = rb;
            nxt_st.sda_oe = ~rb[7];
            nxt_st.state  = ST_RDATA;
          end
        end
        default: begin
          nxt_st.state  = ST_IDLE;
          nxt_st.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_ff       <= '0;
      st_ff.state <= ST_IDLE;
      st_ff.scl_d <= 1'b1;
      st_ff.sda_d <= 1'b1;
      st_ff.mem   <= {RW_COUNT{BANK_RST}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // pins only ever pull low; enables come from flops
  assign sda_out               = 1'b0;
  assign sda_oe                = st_ff.sda_oe;
  assign near_saturation_n_out = 1'b0;
  assign near_saturation_n_oe  = st_ff.near_oe;
  assign fault_n_out           = 1'b0;
  assign fault_n_oe            = st_ff.fault_oe;
  assign soft_clip_en = st_ff.mem[SOFT_CLIP_OFS][SOFT_CLIP_BIT];
  assign parallel_bridge_mode  = st_ff.par_bridge;
  assign bridge_mode           = st_ff.bridge;
  assign single_ended_mode     = st_ff.single_end;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  logic addr_end;
  logic wr_end;
  assign addr_end = !stop_det && !start_det && scl_fall
                    && st_ff.state == ST_ADDR && st_ff.cnt == BITS_PER_BYTE;
  assign wr_end   = !stop_det && !start_det && scl_fall
                    && st_ff.state == ST_WDATA && st_ff.cnt == BITS_PER_BYTE;

  a_addr_ack_hit: assert property (addr_end && addr_hit |=>
      sda_oe && st_ff.state == ST_ADDR_ACK)
    else $error("own address not acknowledged");

  a_addr_miss_idle: assert property (addr_end && !addr_hit |=>
      !sda_oe && st_ff.state == ST_IDLE)
    else $error("foreign address answered");

  a_wr_ptr_inc: assert property (wr_end |=>
      st_ff.ptr == $past(st_ff.ptr) + 7'h01 && sda_oe)
    else $error("write pointer did not advance");

  a_ro_unchanged: assert property (!wr_end |=> $stable(st_ff.mem))
    else $error("bank changed without a write");

  a_ro_write_drop: assert property (wr_end && st_ff.ptr > RW_LAST
      |=> $stable(st_ff.mem))
    else $error("read-only location written");

  a_stop_release: assert property (stop_det |=>
      st_ff.state == ST_IDLE && !sda_oe)
    else $error("stop did not end transfer");

  a_rd_nack_end: assert property (!stop_det && !start_det && scl_rise
      && st_ff.state == ST_RDATA_ACK && sda |=> st_ff.state == ST_IDLE)
    else $error("read continued after no-ack");

  a_fault_pin: assert property (|st_ff.live |=> fault_n_oe)
    else $error("fault pin not pulled low");

  a_fault_sticky: assert property (##1
      (st_ff.acc & $past(st_ff.live)) == $past(st_ff.live))
    else $error("live fault missing from log");

  a_clip_pin: assert property (clip_s |=> near_saturation_n_oe)
    else $error("clip pin not pulled low");

  a_cfg_decode: assert property (##2 $stable(cfg)[*2] |->
      parallel_bridge_mode == (cfg == CFG_PAR_BRIDGE)
      && bridge_mode == ^cfg && single_ended_mode == cfg[0])
    else $error("configuration strap misdecoded");

  c_write_byte: cover property (wr_end ##[1:600] stop_det);
  c_read_byte:  cover property (st_ff.state == ST_RDATA_ACK && scl_rise);
  c_read_burst: cover property (st_ff.more ##[1:300] st_ff.state == ST_RDATA);
  c_log_clear:  cover property (clr_evt && st_ff.acc != 8'h00);

endmodule : icb_ctrl_port
`default_nettype wire

//--- icb_master_model.sv
// bus master model driving the serial clock and data lines of the port
// assumes ref_clk at 25 MHz; both lines have pull-ups, so released = high
`timescale 1ns/1ps
`default_nettype none
module icb_master_model (
  input  wire logic ref_clk,
  input  wire logic sda_out,
  input  wire logic sda_oe,
  output var  logic scl_line,
  output var  logic sda_line
);
  logic m_low;  // master pulls data low

  // wired-and of both parties on the pulled-up data line
  assign sda_line = !(m_low || (sda_oe && !sda_out));

  initial begin
    m_low = 1'b0;
    scl_line = 1'b1;
  end

  // --------------------------------------------------------------------
  // bit and byte level
  // --------------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step

  // 250 ref_clk cycles a bit, 10 us, 100 kbps
  task automatic bitx(input logic b, output logic r);
    m_low = !b;
    step(62);
    scl_line = 1'b1;
    step(125);
    r = sda_line;
    scl_line = 1'b0;
    step(63);
  endtask : bitx

  // bytes go msb first, then the ninth bit for the acknowledge
  task automatic bytex(input logic [7:0] d, input logic mack,
                       output logic [7:0] q, output logic sack);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(mack, sack);
  endtask : bytex

  // start or repeated start: data falls while clock high
  task automatic start();
    m_low = 1'b0;
    step(62);
    scl_line = 1'b1;
    step(62);
    m_low = 1'b1;
    step(62);
    scl_line = 1'b0;
    step(62);
  endtask : start

  // stop: data rises while clock high, then bus free time
  task automatic stop();
    m_low = 1'b1;
    step(62);
    scl_line = 1'b1;
    step(62);
    m_low = 1'b0;
    step(62);
  endtask : stop

  // --------------------------------------------------------------------
  // transactions; ok is high when the device acked every byte
  // --------------------------------------------------------------------
  task automatic write_txn(input logic [6:0] dev, input logic [7:0] ptr,
                           input logic [7:0] d[$], output logic ok);
    logic [7:0] q;
    logic       a;
    start();
    bytex({dev, 1'b0}, 1'b1, q, a);
    ok = !a;
    if (ok) begin
      bytex(ptr, 1'b1, q, a);
      ok &= !a;
      foreach (d[i]) begin
        bytex(d[i], 1'b1, q, a);
        ok &= !a;
      end
    end
    stop();
  endtask : write_txn

  task automatic read_txn(input logic [6:0] dev, input logic [7:0] ptr,
                          input int n, output logic [7:0] d[$],
                          output logic ok);
    logic [7:0] q;
    logic       a;
    d = {};
    start();
    bytex({dev, 1'b0}, 1'b1, q, a);
    ok = !a;
    bytex(ptr, 1'b1, q, a);
    ok &= !a;
    start();
    bytex({dev, 1'b1}, 1'b1, q, a);
    ok &= !a;
    for (int i = 0; i < n; i++) begin
      bytex(8'hFF, i == n - 1, q, a);
      d.push_back(q);
    end
    stop();
  endtask : read_txn
endmodule : icb_master_model
`default_nettype wire

//--- tb_icb_ctrl_port.sv
// self-checking bench for the serial control port and its pins
// assumes icb_pkg and the master model; 25 MHz ref_clk, reset held 10 cycles
`timescale 1ns/1ps
`default_nettype none
module tb_icb_ctrl_port;
  import icb_pkg::*;

  logic       ref_clk, nrst, scl_line, sda_line, sda_out, sda_oe;
  logic       addr_select_0, addr_select_1, out_cfg_sel0, out_cfg_sel1;
  logic [7:0] flt, mod0, mod1;
  logic       near_clip, ns_out, ns_oe, fn_out, fn_oe, soft_clip_en;
  logic       m_par, m_brg, m_sng, ok;
  logic [7:0] wq[$];
  logic [7:0] rq[$];
  int         n_errors, num_checks;
  localparam logic [11:0] MODE_EXP = 12'h29C; // {par,bridge,single} per code

  icb_ctrl_port u_dut (
    .ref_clk(ref_clk), .nrst(nrst), .scl_in(scl_line), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_select_0(addr_select_0), .addr_select_1(addr_select_1),
    .out_cfg_sel0(out_cfg_sel0), .out_cfg_sel1(out_cfg_sel1),
    .direct_current_guard_flag(flt[7]), .pin_short_flag(flt[6]),
    .overtemp_error_flag(flt[5]), .overtemp_warning_flag(flt[4]),
    .undervoltage_flag(flt[3]), .clock_lock_fault(flt[2]),
    .overcurrent_flag(flt[1]), .cap_overvoltage_flag(flt[0]),
    .near_clip(near_clip), .mod_index_ch0(mod0), .mod_index_ch1(mod1),
    .near_saturation_n_out(ns_out), .near_saturation_n_oe(ns_oe),
    .fault_n_out(fn_out), .fault_n_oe(fn_oe), .soft_clip_en(soft_clip_en),
    .parallel_bridge_mode(m_par), .bridge_mode(m_brg),
    .single_ended_mode(m_sng)
  );

  icb_master_model u_master (
    .ref_clk(ref_clk), .sda_out(sda_out), .sda_oe(sda_oe),
    .scl_line(scl_line), .sda_line(sda_line)
  );

  // --------------------------------------------------------------------
  // clock, watchdog, helpers
  // --------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = !ref_clk;
  end

  // tests need about 91k cycles; cut off at 100k
  initial begin
    #4_000_000;
    n_errors++;
    report_and_stop();
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string msg);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  // selects the strapped address, then lets the synchronisers settle
  task automatic strap(input logic [1:0] s);
    {addr_select_1, addr_select_0} = s;
    tick(8);
  endtask : strap

  // --------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    {addr_select_1, addr_select_0, out_cfg_sel0, out_cfg_sel1} = 4'h0;
    flt = 8'h00;
    near_clip = 1'b0;
    mod0 = 8'h3C;
    mod1 = 8'hC3;
    n_errors = 0;
    num_checks = 0;
    tick(10);
    nrst = 1'b1;
    tick(10);
    // output configuration straps, every code
    for (int i = 0; i < 4; i++) begin
      {out_cfg_sel0, out_cfg_sel1} = 2'(i);
      tick(8);
      chk(8'({m_par, m_brg, m_sng}), 8'(MODE_EXP[i*3 +: 3]), "mode");
    end
    // clip pin follows the near-clipping level both ways
    chk(8'(ns_oe), 8'h00, "clip idle");
    near_clip = 1'b1;
    tick(8);
    chk(8'(ns_oe), 8'h01, "clip low");
    near_clip = 1'b0;
    tick(8);
    chk(8'(ns_oe), 8'h00, "clip released");
    // open-drain pins only ever pull low
    chk({5'h00, ns_out, fn_out, sda_out}, 8'h00, "pull levels");
    // foreign address is not acked, own address is
    strap(2'h2);
    wq = {};
    u_master.write_txn({SLAVE_ADDR_HI, 2'h0}, 8'h00, wq, ok);
    chk(8'(ok), 8'h00, "foreign ack");
    wq = {8'hA5, 8'h5A, 8'h3C};
    u_master.write_txn({SLAVE_ADDR_HI, 2'h2}, 8'd79, wq, ok);
    chk(8'(ok), 8'h01, "write ack");
    // burst read across the end of the writable space
    strap(2'h1);
    u_master.read_txn({SLAVE_ADDR_HI, 2'h1}, 8'd79, 3, rq, ok);
    chk(8'(ok), 8'h01, "read ack");
    chk(8'(rq.size()), 8'h03, "read count");
    chk(rq[0], 8'hA5, "loc 79");
    chk(rq[1], 8'h5A, "loc 80");
    chk(rq[2], 8'h00, "loc 81");
    chk(8'(sda_oe), 8'h00, "data released");
    // soft clip enable from bit 7 of location 10
    strap(2'h3);
    chk(8'(soft_clip_en), 8'h00, "soft clip reset");
    wq = {8'h80};
    u_master.write_txn({SLAVE_ADDR_HI, 2'h3}, 8'h0A, wq, ok);
    chk(8'(soft_clip_en), 8'h01, "soft clip on");
    // modulation indices at 98 and 102, unmapped between
    u_master.read_txn({SLAVE_ADDR_HI, 2'h3}, 8'd98, 5, rq, ok);
    for (int i = 0; i < 5; i++) begin
      chk(rq[i], i == 0 ? 8'h3C : i == 4 ? 8'hC3 : 8'h00, "mod idx");
    end
    // live, sticky and cleared fault vectors
    flt = 8'h92;
    tick(8);
    chk(8'(fn_oe), 8'h01, "fault pin");
    u_master.read_txn({SLAVE_ADDR_HI, 2'h3}, 8'd124, 1, rq, ok);
    chk(rq[0], 8'h92, "live faults");
    flt = 8'h00;
    tick(8);
    chk(8'(fn_oe), 8'h00, "fault pin off");
    u_master.read_txn({SLAVE_ADDR_HI, 2'h3}, 8'd109, 1, rq, ok);
    chk(rq[0], 8'h92, "fault log");
    wq = {8'h04};
    u_master.write_txn({SLAVE_ADDR_HI, 2'h3}, 8'd45, wq, ok);
    u_master.read_txn({SLAVE_ADDR_HI, 2'h3}, 8'd109, 1, rq, ok);
    chk(rq[0], 8'h00, "fault log cleared");
    report_and_stop();
  end
endmodule : tb_icb_ctrl_port
`default_nettype wire
